//--- src/io_alloc_pkg.sv
package io_alloc_pkg;

    // Sizes of the routing matrix
    localparam int NUM_TERMS = 7;
    localparam int NUM_IN_FUNCS = 9;
    localparam int NUM_OUT_FUNCS = 9;
    localparam int NUM_CIRCUITS = 3;

    // Input selection digit codes
    localparam logic [3:0] SEL_TERM_LAST = 4'h6;
    localparam logic [3:0] SEL_FORCE_ON = 4'h7;
    localparam logic [3:0] SEL_FORCE_OFF = 4'h8;
    localparam logic [3:0] SEL_INV_FIRST = 4'h9;
    localparam logic [2:0] LATCH_FIRST_TERM = 3'h4;

    // Output selection digit: 0 leaves the function unused, 1..3 pick a circuit
    localparam logic [1:0] OSEL_UNUSED = 2'h0;

    // Input function positions in the internal vector
    localparam int IF_FWD_OT = 0;
    localparam int IF_REV_OT = 1;
    localparam int IF_FWD_TLIM = 2;
    localparam int IF_REV_TLIM = 3;
    localparam int IF_HOMING_DEC = 4;
    localparam int IF_LATCH_ONE = 5;
    localparam int IF_LATCH_TWO = 6;
    localparam int IF_LATCH_THREE = 7;
    localparam int IF_DB_ANSWER = 8;

    // Output function positions in the internal vector
    localparam int OF_POS_COMPLETE = 0;
    localparam int OF_SPEED_COINCIDE = 1;
    localparam int OF_ROTATION = 2;
    localparam int OF_SERVO_READY = 3;
    localparam int OF_TORQUE_LIM_DET = 4;
    localparam int OF_SPEED_LIM_DET = 5;
    localparam int OF_BRAKE = 6;
    localparam int OF_WARNING = 7;
    localparam int OF_NEAR = 8;

    // Present control mode of the drive
    typedef enum logic [1:0] {
        MODE_POSITION,
        MODE_SPEED,
        MODE_TORQUE
    } ctrl_mode_e;

    // Reset values
    localparam logic [NUM_TERMS-1:0] TERM_RESET = 7'h00;
    localparam logic [NUM_IN_FUNCS-1:0] IN_FUNC_RESET = 9'h000;
    localparam logic [NUM_CIRCUITS-1:0] CIRCUIT_RESET = 3'h0;

endpackage : io_alloc_pkg

//--- src/input_route.sv
`timescale 1ns/10ps

module input_route #(
    parameter bit NORMAL_HIGH = 1'b0,
    parameter bit LATCH_ONLY = 1'b0
) (
    // Selection digit
    input wire logic [3:0] sel_in,
    // Filtered terminal levels, bit 0 is terminal 40
    input wire logic [io_alloc_pkg::NUM_TERMS-1:0] term_in,
    // Function state, 1 = asserted
    output logic asserted_out
);

    logic [2:0] idx;
    logic inv;
    logic level;

    // Decode the digit into terminal, polarity or forced state
    always_comb begin
        idx = 3'h0;
        inv = 1'b0;
        level = 1'b0;
        asserted_out = 1'b0;
        if (sel_in <= io_alloc_pkg::SEL_TERM_LAST) begin
            idx = sel_in[2:0]; // R01
        end else if (sel_in >= io_alloc_pkg::SEL_INV_FIRST) begin
            idx = 3'(sel_in - io_alloc_pkg::SEL_INV_FIRST); // R03
            inv = 1'b1; // R03
        end
        level = term_in[idx]; // R06
        if (sel_in == io_alloc_pkg::SEL_FORCE_ON) begin
            asserted_out = 1'b1; // R02
        end else if (sel_in == io_alloc_pkg::SEL_FORCE_OFF) begin
            asserted_out = 1'b0; // R02
        end else if (LATCH_ONLY && idx < io_alloc_pkg::LATCH_FIRST_TERM) begin
            asserted_out = 1'b0; // R05
        end else begin
            asserted_out = (NORMAL_HIGH ^ inv) ? level : ~level; // R04
        end
    end

endmodule : input_route

//--- src/servo_io_signal_allocation.sv
// Overview of operation
// R01 - Digits 0-6 pick terminals 40-46
// R02 - Digit 7 forces on, 8 forces off
// R03 - Digits 9-F pick terminals, inverted level
// R04 - Overtravel normal high; others normal low
// R05 - Latches only on terminals 44-46 or forced
// R06 - One terminal drives all functions selecting it
// R07 - Functions sharing a circuit are ORed
// R08 - Functions not evaluated in mode are invalid
// R09 - Brake defaults to negative logic
// R10 - Output digit 1-3 picks circuit, 0 unused
// R11 - Terminals synchronised before routing
`timescale 1ns/10ps

module servo_io_signal_allocation (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // Input terminals 40..46 as bit 0..6, 1 = high level
    input wire logic [io_alloc_pkg::NUM_TERMS-1:0] term_level_in,
    // Input function selection digits
    input wire logic [3:0] fwd_overtravel_select_in,
    input wire logic [3:0] rev_overtravel_select_in,
    input wire logic [3:0] fwd_torque_limit_select_in,
    input wire logic [3:0] rev_torque_limit_select_in,
    input wire logic [3:0] homing_decel_select_in,
    input wire logic [3:0] latch_one_select_in,
    input wire logic [3:0] latch_two_select_in,
    input wire logic [3:0] latch_three_select_in,
    input wire logic [3:0] brake_answer_select_in,
    // Present control mode
    input wire io_alloc_pkg::ctrl_mode_e ctrl_mode_in,
    // Internal output function states, 1 = ON
    input wire logic positioning_complete_in,
    input wire logic speed_coincide_in,
    input wire logic rotation_detect_in,
    input wire logic servo_ready_in,
    input wire logic torque_limit_detect_in,
    input wire logic speed_limit_detect_in,
    input wire logic holding_brake_in,
    input wire logic warning_in,
    input wire logic near_in,
    // Output function selection digits
    input wire logic [1:0] positioning_complete_select_in,
    input wire logic [1:0] speed_coincide_select_in,
    input wire logic [1:0] rotation_detect_select_in,
    input wire logic [1:0] servo_ready_select_in,
    input wire logic [1:0] torque_limit_detect_select_in,
    input wire logic [1:0] speed_limit_detect_select_in,
    input wire logic [1:0] holding_brake_select_in,
    input wire logic [1:0] warning_select_in,
    input wire logic [1:0] near_select_in,
    // Output options
    input wire logic brake_positive_logic_in,
    input wire logic [io_alloc_pkg::NUM_CIRCUITS-1:0] circuit_invert_in,
    // Input function states, 1 = asserted
    output logic fwd_overtravel_out,
    output logic rev_overtravel_out,
    output logic fwd_ext_torque_limit_out,
    output logic rev_ext_torque_limit_out,
    output logic homing_decel_switch_out,
    output logic ext_latch_one_out,
    output logic ext_latch_two_out,
    output logic ext_latch_three_out,
    output logic dyn_brake_answer_out,
    // Output circuits 1..3 as bit 0..2, 1 = circuit ON
    output logic [io_alloc_pkg::NUM_CIRCUITS-1:0] circuit_on_out
);

    // Short local names for the matrix sizes
    localparam int NT = io_alloc_pkg::NUM_TERMS;
    localparam int NI = io_alloc_pkg::NUM_IN_FUNCS;
    localparam int NO = io_alloc_pkg::NUM_OUT_FUNCS;
    localparam int NC = io_alloc_pkg::NUM_CIRCUITS;

    // Whole state: sync stages, filtered levels, functions, circuits
    typedef struct packed {
        logic [NT-1:0] sync1;
        logic [NT-1:0] sync2;
        logic [NT-1:0] sync3;
        logic [NT-1:0] filt;
        logic [NI-1:0] func;
        logic [NC-1:0] circ;
    } state_s;

    // Current state and its next value
    state_s state_ff;
    state_s nxt_state;
    // Reset release and routing helpers
    logic [1:0] rst_sync_ff;
    logic rst_n;
    logic [3:0] in_sel [NI];
    logic [NI-1:0] in_asserted;
    logic [NO-1:0] out_func;
    logic [1:0] out_sel [NO];
    logic [NO-1:0] out_valid;

    // Reset release through two flops
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // Gather selection digits and function states in index order
    always_comb begin
        in_sel[io_alloc_pkg::IF_FWD_OT] = fwd_overtravel_select_in;
        in_sel[io_alloc_pkg::IF_REV_OT] = rev_overtravel_select_in;
        in_sel[io_alloc_pkg::IF_FWD_TLIM] = fwd_torque_limit_select_in;
        in_sel[io_alloc_pkg::IF_REV_TLIM] = rev_torque_limit_select_in;
        in_sel[io_alloc_pkg::IF_HOMING_DEC] = homing_decel_select_in;
        in_sel[io_alloc_pkg::IF_LATCH_ONE] = latch_one_select_in;
        in_sel[io_alloc_pkg::IF_LATCH_TWO] = latch_two_select_in;
        in_sel[io_alloc_pkg::IF_LATCH_THREE] = latch_three_select_in;
        in_sel[io_alloc_pkg::IF_DB_ANSWER] = brake_answer_select_in;
        out_sel[io_alloc_pkg::OF_POS_COMPLETE] = positioning_complete_select_in;
        out_sel[io_alloc_pkg::OF_SPEED_COINCIDE] = speed_coincide_select_in;
        out_sel[io_alloc_pkg::OF_ROTATION] = rotation_detect_select_in;
        out_sel[io_alloc_pkg::OF_SERVO_READY] = servo_ready_select_in;
        out_sel[io_alloc_pkg::OF_TORQUE_LIM_DET] = torque_limit_detect_select_in;
        out_sel[io_alloc_pkg::OF_SPEED_LIM_DET] = speed_limit_detect_select_in;
        out_sel[io_alloc_pkg::OF_BRAKE] = holding_brake_select_in;
        out_sel[io_alloc_pkg::OF_WARNING] = warning_select_in;
        out_sel[io_alloc_pkg::OF_NEAR] = near_select_in;
        out_func[io_alloc_pkg::OF_POS_COMPLETE] = positioning_complete_in;
        out_func[io_alloc_pkg::OF_SPEED_COINCIDE] = speed_coincide_in;
        out_func[io_alloc_pkg::OF_ROTATION] = rotation_detect_in;
        out_func[io_alloc_pkg::OF_SERVO_READY] = servo_ready_in;
        out_func[io_alloc_pkg::OF_TORQUE_LIM_DET] = torque_limit_detect_in;
        out_func[io_alloc_pkg::OF_SPEED_LIM_DET] = speed_limit_detect_in;
        out_func[io_alloc_pkg::OF_BRAKE] = holding_brake_in ^ brake_positive_logic_in; // R09
        out_func[io_alloc_pkg::OF_WARNING] = warning_in;
        out_func[io_alloc_pkg::OF_NEAR] = near_in;
    end

    // Functions only evaluated in some control modes
    always_comb begin
        out_valid = '1;
        unique case (ctrl_mode_in)
            io_alloc_pkg::MODE_POSITION: begin
                out_valid[io_alloc_pkg::OF_SPEED_LIM_DET] = 1'b0; // R08
            end
            io_alloc_pkg::MODE_SPEED: begin
                out_valid[io_alloc_pkg::OF_POS_COMPLETE] = 1'b0; // R08
                out_valid[io_alloc_pkg::OF_NEAR] = 1'b0; // R08
                out_valid[io_alloc_pkg::OF_SPEED_LIM_DET] = 1'b0; // R08
            end
            io_alloc_pkg::MODE_TORQUE: begin
                out_valid[io_alloc_pkg::OF_POS_COMPLETE] = 1'b0; // R08
                out_valid[io_alloc_pkg::OF_NEAR] = 1'b0; // R08
                out_valid[io_alloc_pkg::OF_SPEED_COINCIDE] = 1'b0; // R08
            end
            default: begin
                out_valid = '0;
            end
        endcase
    end

    // One decoder per input function on the filtered terminals
    generate
        for (genvar i = 0; i < NI; i++) begin : g_in
            input_route #(
                .NORMAL_HIGH(i == io_alloc_pkg::IF_FWD_OT || i == io_alloc_pkg::IF_REV_OT),
                .LATCH_ONLY(i >= io_alloc_pkg::IF_LATCH_ONE && i <= io_alloc_pkg::IF_LATCH_THREE)
            ) u_route (
                .sel_in(in_sel[i]),
                .term_in(state_ff.filt),
                .asserted_out(in_asserted[i])
            );
        end
    endgenerate

    // Next state: synchroniser, glitch filter, routing
    always_comb begin
        nxt_state = state_ff;
        nxt_state.sync1 = term_level_in; // R11
        nxt_state.sync2 = state_ff.sync1;
        nxt_state.sync3 = state_ff.sync2;
        for (int t = 0; t < NT; t++) begin
            if (state_ff.sync2[t] == state_ff.sync3[t]) begin
                nxt_state.filt[t] = state_ff.sync3[t]; // R11
            end
        end
        // Decoded functions are registered so the outputs come from flops
        nxt_state.func = in_asserted;
        // Each circuit is its polarity bit XOR the OR of its valid functions
        for (int c = 0; c < NC; c++) begin
            nxt_state.circ[c] = circuit_invert_in[c];
            // Digit 0 keeps a function off every circuit
            for (int f = 0; f < NO; f++) begin
                if (out_sel[f] != io_alloc_pkg::OSEL_UNUSED && 32'(out_sel[f]) == c + 1) begin // R10
                    nxt_state.circ[c] = nxt_state.circ[c] ^
                        ((out_func[f] & out_valid[f]) & ~(nxt_state.circ[c] ^ circuit_invert_in[c])); // R07
                end
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= '{sync1: io_alloc_pkg::TERM_RESET, sync2: io_alloc_pkg::TERM_RESET,
                          sync3: io_alloc_pkg::TERM_RESET, filt: io_alloc_pkg::TERM_RESET,
                          func: io_alloc_pkg::IN_FUNC_RESET, circ: io_alloc_pkg::CIRCUIT_RESET};
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Outputs straight from the state register
    assign fwd_overtravel_out = state_ff.func[io_alloc_pkg::IF_FWD_OT];
    assign rev_overtravel_out = state_ff.func[io_alloc_pkg::IF_REV_OT];
    assign fwd_ext_torque_limit_out = state_ff.func[io_alloc_pkg::IF_FWD_TLIM];
    assign rev_ext_torque_limit_out = state_ff.func[io_alloc_pkg::IF_REV_TLIM];
    assign homing_decel_switch_out = state_ff.func[io_alloc_pkg::IF_HOMING_DEC];
    assign ext_latch_one_out = state_ff.func[io_alloc_pkg::IF_LATCH_ONE];
    assign ext_latch_two_out = state_ff.func[io_alloc_pkg::IF_LATCH_TWO];
    assign ext_latch_three_out = state_ff.func[io_alloc_pkg::IF_LATCH_THREE];
    assign dyn_brake_answer_out = state_ff.func[io_alloc_pkg::IF_DB_ANSWER];
    assign circuit_on_out = state_ff.circ;

endmodule : servo_io_signal_allocation

//--- bench/io_alloc_sva.sv
`timescale 1ns/10ps

module io_alloc_sva (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // Terminals and input digits
    input wire logic [6:0] term_level_in,
    input wire logic [3:0] fwd_overtravel_select_in,
    input wire logic [3:0] rev_overtravel_select_in,
    input wire logic [3:0] rev_torque_limit_select_in,
    input wire logic [3:0] homing_decel_select_in,
    input wire logic [3:0] latch_one_select_in,
    input wire logic [3:0] latch_two_select_in,
    // Output side controls
    input wire logic positioning_complete_in,
    input wire logic [1:0] positioning_complete_select_in,
    input wire io_alloc_pkg::ctrl_mode_e ctrl_mode_in,
    input wire logic [2:0] circuit_invert_in,
    // Watched outputs
    input wire logic fwd_overtravel_out,
    input wire logic rev_overtravel_out,
    input wire logic rev_ext_torque_limit_out,
    input wire logic homing_decel_switch_out,
    input wire logic ext_latch_one_out,
    input wire logic ext_latch_two_out,
    input wire logic [2:0] circuit_on_out
);
    logic [2:0] up_cnt_ff;
    logic up;

    // Edges since reset release; outputs are trusted only once the sync chain is clear
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            up_cnt_ff <= 3'h0;
        end else if (up_cnt_ff != 3'h7) begin
            up_cnt_ff <= up_cnt_ff + 3'h1;
        end
    end
    assign up = (up_cnt_ff >= 3'h5);

    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);

    // Forced codes and terminal decoding
    chk_force_on: assert property (up && fwd_overtravel_select_in == 4'h7 |=> fwd_overtravel_out)
        else $error("forced on code left function off");
    chk_force_off: assert property (rev_overtravel_select_in == 4'h8 |=> !rev_overtravel_out)
        else $error("forced off code left function on");
    chk_ot_high: assert property ((up && fwd_overtravel_select_in == 4'h0 && term_level_in[0])[*7]
        |-> fwd_overtravel_out) else $error("overtravel not asserted by high terminal");
    chk_dec_low: assert property ((up && homing_decel_select_in == 4'h3 && !term_level_in[3])[*7]
        |-> homing_decel_switch_out) else $error("homing switch not asserted by low terminal");
    chk_inv_level: assert property ((up && rev_torque_limit_select_in == 4'hf && term_level_in[6])[*7]
        |-> rev_ext_torque_limit_out) else $error("inverted code did not flip level");
    chk_latch_bar: assert property (latch_one_select_in < 4'h4 |=> !ext_latch_one_out)
        else $error("latch asserted from barred terminal");
    chk_latch_ok: assert property ((up && latch_two_select_in == 4'hd && term_level_in[4])[*7]
        |-> ext_latch_two_out) else $error("latch on terminal 44 inverted not asserted");
    // Output routing and validity
    chk_circuit_or: assert property (up && positioning_complete_in && positioning_complete_select_in == 2'h1
        && ctrl_mode_in == io_alloc_pkg::MODE_POSITION && !circuit_invert_in[0] |=> circuit_on_out[0])
        else $error("routed function did not turn circuit on");
    chk_mode_void: assert property (up && ctrl_mode_in == io_alloc_pkg::ctrl_mode_e'(2'h3)
        && circuit_invert_in == 3'h0 |=> circuit_on_out == 3'h0) else $error("invalid functions drove a circuit");

    // Main scenarios reached
    cov_forced: cover property (up && fwd_overtravel_select_in == 4'h7);
    cov_latch: cover property (up && latch_two_select_in == 4'hd && term_level_in[4]);
    cov_void: cover property (up && ctrl_mode_in == io_alloc_pkg::ctrl_mode_e'(2'h3));
endmodule : io_alloc_sva

//--- bench/host_relay.sv
`timescale 1ns/10ps

module host_relay (
    // Clock
    input wire logic clk_in,
    // Wanted contact levels and a one-cycle bounce mask
    input wire logic [6:0] level_in,
    input wire logic [6:0] bounce_in,
    // Terminal levels seen by the drive
    output logic [6:0] term_out
);
    // Contacts follow one cycle late; bounce flips them briefly
    always_ff @(posedge clk_in) begin
        term_out <= level_in ^ bounce_in;
    end
endmodule : host_relay

//--- bench/servo_io_signal_allocation_bench.sv
`timescale 1ns/10ps

module servo_io_signal_allocation_bench;
    logic sys_clk_in, reset_n_in;
    logic [6:0] lvl, bnc, term;
    logic [8:0][3:0] isel;
    logic [8:0][1:0] osel;
    logic [8:0] ofun, fo;
    logic [2:0] inv, co;
    logic bpos;
    io_alloc_pkg::ctrl_mode_e mode;
    int n_fail, n_tests, cyc;

    host_relay u_host_relay (.clk_in(sys_clk_in), .level_in(lvl), .bounce_in(bnc), .term_out(term));

    servo_io_signal_allocation u_servo_io_signal_allocation (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .term_level_in(term),
        .fwd_overtravel_select_in(isel[0]), .rev_overtravel_select_in(isel[1]), .fwd_torque_limit_select_in(isel[2]),
        .rev_torque_limit_select_in(isel[3]), .homing_decel_select_in(isel[4]), .latch_one_select_in(isel[5]),
        .latch_two_select_in(isel[6]), .latch_three_select_in(isel[7]), .brake_answer_select_in(isel[8]),
        .ctrl_mode_in(mode), .positioning_complete_in(ofun[0]), .speed_coincide_in(ofun[1]),
        .rotation_detect_in(ofun[2]), .servo_ready_in(ofun[3]), .torque_limit_detect_in(ofun[4]),
        .speed_limit_detect_in(ofun[5]), .holding_brake_in(ofun[6]), .warning_in(ofun[7]), .near_in(ofun[8]),
        .positioning_complete_select_in(osel[0]), .speed_coincide_select_in(osel[1]),
        .rotation_detect_select_in(osel[2]), .servo_ready_select_in(osel[3]),
        .torque_limit_detect_select_in(osel[4]), .speed_limit_detect_select_in(osel[5]),
        .holding_brake_select_in(osel[6]), .warning_select_in(osel[7]), .near_select_in(osel[8]),
        .brake_positive_logic_in(bpos), .circuit_invert_in(inv),
        .fwd_overtravel_out(fo[0]), .rev_overtravel_out(fo[1]), .fwd_ext_torque_limit_out(fo[2]),
        .rev_ext_torque_limit_out(fo[3]), .homing_decel_switch_out(fo[4]), .ext_latch_one_out(fo[5]),
        .ext_latch_two_out(fo[6]), .ext_latch_three_out(fo[7]), .dyn_brake_answer_out(fo[8]), .circuit_on_out(co));

    // Expected input function states from digits and steady terminal levels
    function automatic logic [8:0] exp_in(logic [8:0][3:0] s, logic [6:0] t);
        logic [3:0] i;
        logic a;
        for (int f = 0; f < 9; f++) begin
            i = (s[f] >= 4'h9) ? s[f] - 4'h9 : s[f];
            a = (f < 2) ? t[i[2:0]] : !t[i[2:0]];
            a = (s[f] >= 4'h9) ? !a : a;
            a = (s[f] == 4'h7) ? 1'b1 : (s[f] == 4'h8) ? 1'b0 : a;
            exp_in[f] = (f >= 5 && f <= 7 && i < 4'h4) ? 1'b0 : a;
        end
    endfunction : exp_in

    // Expected circuits: OR of valid routed functions, then per-circuit inversion
    function automatic logic [2:0] exp_out(logic [8:0][1:0] s, logic [8:0] v, logic [1:0] m, logic bp, logic [2:0] iv);
        logic [8:0] ok;
        logic [2:0] o;
        ok = (m == 2'h0) ? 9'h1df : (m == 2'h1) ? 9'h0de : (m == 2'h2) ? 9'h0fc : 9'h000;
        v[6] = v[6] ^ bp;
        o = 3'h0;
        for (int f = 0; f < 9; f++) begin
            if (ok[f] && v[f] && s[f] != 2'h0) begin
                o[s[f] - 2'h1] = 1'b1;
            end
        end
        exp_out = o ^ iv;
    endfunction : exp_out

    task automatic check(logic [8:0] got, logic [8:0] exp, string what);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic settle(int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask : settle

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    // Free-running clock
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    // Hang guard
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            give_verdict();
        end
    end

    // Main sequence
    initial begin
        reset_n_in = 1'b0;
        {lvl, bnc, isel, osel, ofun, inv, bpos, cyc, n_fail, n_tests} = '0;
        mode = io_alloc_pkg::MODE_POSITION;
        void'($urandom(25975));
        repeat (8) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        settle(4);
        // Every code on every function at once, all sharing one terminal
        for (int k = 0; k < 32; k++) begin
            @(posedge sys_clk_in);
            isel <= {9{k[3:0]}};
            lvl <= k[4] ? 7'h0e : 7'h71;
            settle(9);
            check(fo, exp_in(isel, lvl), "code sweep");
        end
        $display("code sweep done");
        // Random digits and levels, then a one-cycle contact bounce
        for (int k = 0; k < 40; k++) begin
            @(posedge sys_clk_in);
            isel <= 36'({$urandom(), $urandom()});
            lvl <= 7'($urandom());
            settle(9);
            check(fo, exp_in(isel, lvl), "random inputs");
            @(posedge sys_clk_in);
            bnc <= 7'($urandom());
            @(posedge sys_clk_in);
            bnc <= 7'h00;
            // Look every cycle while the glitch walks through the sync chain
            repeat (8) begin
                settle(1);
                check(fo, exp_in(isel, lvl), "bounce");
            end
        end
        $display("random inputs done");
        // Output routing: three corners then random
        for (int k = 0; k < 63; k++) begin
            @(posedge sys_clk_in);
            osel <= (k < 3) ? 18'h15555 : 18'($urandom());
            ofun <= (k < 3) ? 9'h001 : 9'($urandom());
            mode <= io_alloc_pkg::ctrl_mode_e'(2'((k < 3) ? (k == 0 ? 1 : k == 1 ? 0 : 3) : $urandom_range(3)));
            inv <= (k < 3) ? 3'h0 : 3'($urandom());
            bpos <= (k >= 3) && ($urandom_range(7) == 0);
            settle(2);
            check({6'h00, co}, {6'h00, exp_out(osel, ofun, mode, bpos, inv)}, "circuits");
        end
        $display("output routing done");
        give_verdict();
    end
endmodule : servo_io_signal_allocation_bench

bind servo_io_signal_allocation io_alloc_sva u_io_alloc_sva (.sys_clk_in, .reset_n_in, .term_level_in,
    .fwd_overtravel_select_in, .rev_overtravel_select_in, .rev_torque_limit_select_in, .homing_decel_select_in,
    .latch_one_select_in, .latch_two_select_in, .positioning_complete_in, .positioning_complete_select_in,
    .ctrl_mode_in, .circuit_invert_in, .fwd_overtravel_out, .rev_overtravel_out, .rev_ext_torque_limit_out,
    .homing_decel_switch_out, .ext_latch_one_out, .ext_latch_two_out, .circuit_on_out);
